// ===== core/sample_fifo_alignment_control.sv
// Sample FIFO alignment control between the lane clock and the DAC clock
// How it works
// - The low five bits of the FIFO 3 readback register report the release delay that would consume samples on arrival.
// - That value is the DAC clock count from the effective SYSREF edge to first sample, less 3 in lane mode 0 and less 1 otherwise.
// - Writing one to the strobe realign bit while it holds zero starts one realignment to the lane receiver.
// - The strobe realignment takes lane bank 0 as reference when that bank is active, else lane bank 2.
// - A strobe realignment that changes the FIFO alignment sets the clock realigned alarm.
// - The strobe realignment uses the receiver's current alignment at once and never waits for a strobe.
// - After a SYSREF synchronisation, strobe requests are ignored until reset or the datapath enable drops.
// - While SYSREF realign is enabled the FIFO realigns on every detected SYSREF edge.
// - A misaligned SYSREF edge with realign enabled realigns the clocks and sets the clock realigned alarm.
// - With realign disabled a SYSREF edge leaves the alignment alone but a misaligned one sets the misalign alarm.
// - A SYSREF edge just before the write that sets the enable may still be used for alignment.
// - The release delay sets how many DAC clocks after the effective SYSREF edge the first samples are read.
`timescale 1ns/10ps
`default_nettype none
module sample_fifo_alignment_control (
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   lane_clk_i,
  input  wire logic                   spi_sclk_i,
  input  wire logic                   spi_cs_n_i,
  input  wire logic                   spi_sdi_i,
  output logic                        spi_sdo_o,
  output logic                        spi_sdo_oe_o,
  input  wire logic                   sysref_i,
  input  wire logic                   strobe_bank0_i,
  input  wire logic                   strobe_bank2_i,
  input  wire logic                   bank0_active_i,
  input  wire logic                   datapath_enable_i,
  input  wire logic [1:0]             lane_mode_i,
  input  wire logic [4:0]             fifo_release_delay_i,
  input  wire logic                   sample_avail_i,
  input  wire fifo_align_pkg::alarm_t alarm_clear_i,
  output fifo_align_pkg::alarm_t      alarm_o,
  output logic [2:0]                  fifo_phase_o,
  output logic                        release_start_o
);
  // ----------------------------------------
  // Pin synchronisers on the DAC clock
  // ----------------------------------------
  logic [1:0] sclk_s_q, cs_s_q, sdi_s_q, ref_s_q, dp_s_q;
  logic       sclk_d1_q, ref_d1_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_s_q  <= 2'h0;
      cs_s_q    <= 2'h3;
      sdi_s_q   <= 2'h0;
      ref_s_q   <= 2'h0;
      dp_s_q    <= 2'h0;
      sclk_d1_q <= 1'b0;
      ref_d1_q  <= 1'b0;
    end else begin
      sclk_s_q  <= {sclk_s_q[0], spi_sclk_i};
      cs_s_q    <= {cs_s_q[0], spi_cs_n_i};
      sdi_s_q   <= {sdi_s_q[0], spi_sdi_i};
      ref_s_q   <= {ref_s_q[0], sysref_i};
      dp_s_q    <= {dp_s_q[0], datapath_enable_i};
      sclk_d1_q <= sclk_s_q[1];
      ref_d1_q  <= ref_s_q[1];
    end
  end
  logic sclk_rise, sclk_fall, sysref_edge, datapath_enable;
  assign sclk_rise   = sclk_s_q[1] & ~sclk_d1_q;
  assign sclk_fall   = ~sclk_s_q[1] & sclk_d1_q;
  assign sysref_edge = ref_s_q[1] & ~ref_d1_q;
  assign datapath_enable       = dp_s_q[1];

  // ----------------------------------------
  // Serial control port slave
  // ----------------------------------------
  fifo_align_pkg::spi_state_t spi_q;
  logic [4:0]  bit_cnt_q;
  logic [22:0] shift_q;
  logic [7:0]  sdo_sr_q;
  logic [7:0]  ctrl_q;
  logic [4:0]  latency_q;
  logic        wr_pulse_q;
  logic [7:0]  wr_data_q;
  logic [14:0] wr_addr_q;
  function automatic logic [7:0] read_mux(input logic [14:0] a);
    case (a)
      fifo_align_pkg::ADDR_LATENCY_RB3: read_mux = {3'h0, latency_q};
      fifo_align_pkg::ADDR_ALIGN_CTRL:  read_mux = ctrl_q;
      default:                          read_mux = 8'h00;
    endcase
  endfunction : read_mux
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      spi_q      <= fifo_align_pkg::SPI_IDLE;
      bit_cnt_q  <= 5'h00;
      shift_q    <= 23'h000000;
      sdo_sr_q   <= 8'h00;
      wr_pulse_q <= 1'b0;
      wr_data_q  <= 8'h00;
      wr_addr_q  <= 15'h0000;
    end else begin
      wr_pulse_q <= 1'b0;
      case (spi_q)
        fifo_align_pkg::SPI_IDLE: begin
          bit_cnt_q <= 5'h00;
          if (!cs_s_q[1]) begin
            spi_q <= fifo_align_pkg::SPI_SHIFT;
          end
        end
        fifo_align_pkg::SPI_SHIFT: begin
          if (cs_s_q[1]) begin
            spi_q <= fifo_align_pkg::SPI_IDLE;
          end else if (sclk_rise) begin
            shift_q   <= {shift_q[21:0], sdi_s_q[1]};
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == fifo_align_pkg::SPI_CNT_ADDR - 5'h01) begin
              sdo_sr_q <= read_mux({shift_q[13:0], sdi_s_q[1]});
            end
            if (bit_cnt_q == fifo_align_pkg::SPI_CNT_LAST) begin
              spi_q      <= fifo_align_pkg::SPI_IDLE;
              wr_pulse_q <= ~shift_q[22];
              wr_addr_q  <= shift_q[21:7];
              wr_data_q  <= {shift_q[6:0], sdi_s_q[1]};
            end
          end else if (sclk_fall && bit_cnt_q > fifo_align_pkg::SPI_CNT_ADDR) begin
            sdo_sr_q <= {sdo_sr_q[6:0], 1'b0};
          end
        end
        default: spi_q <= fifo_align_pkg::SPI_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      spi_sdo_o    <= 1'b0;
      spi_sdo_oe_o <= 1'b0;
    end else begin
      spi_sdo_o    <= sdo_sr_q[7];
      spi_sdo_oe_o <= (spi_q == fifo_align_pkg::SPI_SHIFT) && shift_q[bit_cnt_q - 5'h01]
                      && (bit_cnt_q >= fifo_align_pkg::SPI_CNT_ADDR) && !cs_s_q[1];
    end
  end

  // ----------------------------------------
  // Control register and strobe realign request
  // ----------------------------------------
  logic ctrl_wr, strobe_req, synced_q, stb_done;
  assign ctrl_wr    = wr_pulse_q && (wr_addr_q == fifo_align_pkg::ADDR_ALIGN_CTRL);
  // Rising write of the request bit; locked out once SYSREF sync has happened
  assign strobe_req = ctrl_wr && wr_data_q[fifo_align_pkg::BIT_STROBE_REQ]
                      && !ctrl_q[fifo_align_pkg::BIT_STROBE_REQ] && !synced_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= fifo_align_pkg::ALIGN_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= wr_data_q;
    end
  end

  // ----------------------------------------
  // Lane clock domain: receiver alignment
  // ----------------------------------------
  logic [1:0] bank0_s_q, req_s_q;
  logic       req_d1_q, stb0_d_q, stb2_d_q, ack_tgl_q, req_tgl_q;
  logic [2:0] lphase_q, lhold_q;
  logic       stb_rise;
  // Reference strobe: bank 0 when active, bank 2 otherwise
  assign stb_rise = bank0_s_q[1] ? (strobe_bank0_i & ~stb0_d_q)
                                 : (strobe_bank2_i & ~stb2_d_q);
  always_ff @(posedge lane_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bank0_s_q <= 2'h0;
      req_s_q   <= 2'h0;
      req_d1_q  <= 1'b0;
      stb0_d_q  <= 1'b0;
      stb2_d_q  <= 1'b0;
      lphase_q  <= fifo_align_pkg::PHASE_ZERO;
      lhold_q   <= fifo_align_pkg::PHASE_ZERO;
      ack_tgl_q <= 1'b0;
    end else begin
      bank0_s_q <= {bank0_s_q[0], bank0_active_i};
      req_s_q   <= {req_s_q[0], req_tgl_q};
      req_d1_q  <= req_s_q[1];
      stb0_d_q  <= strobe_bank0_i;
      stb2_d_q  <= strobe_bank2_i;
      lphase_q  <= stb_rise ? fifo_align_pkg::PHASE_ZERO : lphase_q + fifo_align_pkg::PHASE_ONE;
      // Current receiver alignment is captured at once, no strobe awaited
      if (req_s_q[1] != req_d1_q) begin
        lhold_q   <= lphase_q;
        ack_tgl_q <= ~ack_tgl_q;
      end
    end
  end

  // ----------------------------------------
  // Strobe realign handshake on the DAC clock
  // ----------------------------------------
  fifo_align_pkg::strobe_state_t stb_q;
  logic       ack_d1_q;
  logic [1:0] ack_s_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      stb_q     <= fifo_align_pkg::STB_IDLE;
      req_tgl_q <= 1'b0;
      ack_s_q   <= 2'h0;
      ack_d1_q  <= 1'b0;
    end else begin
      ack_s_q  <= {ack_s_q[0], ack_tgl_q};
      ack_d1_q <= ack_s_q[1];
      case (stb_q)
        fifo_align_pkg::STB_IDLE: begin
          // Only an explicit request reaches the receiver
          if (strobe_req) begin
            req_tgl_q <= ~req_tgl_q;
            stb_q     <= fifo_align_pkg::STB_WAIT;
          end
        end
        fifo_align_pkg::STB_WAIT: begin
          if (ack_s_q[1] != ack_d1_q) begin
            stb_q <= fifo_align_pkg::STB_DONE;
          end
        end
        fifo_align_pkg::STB_DONE: stb_q <= fifo_align_pkg::STB_IDLE;
        default: stb_q <= fifo_align_pkg::STB_IDLE;
      endcase
    end
  end
  assign stb_done = (stb_q == fifo_align_pkg::STB_DONE);

  // ----------------------------------------
  // SYSREF processing and FIFO phase
  // ----------------------------------------
  logic [2:0] phase_q;
  logic       sref_en, sref_misaligned, sref_realign, stb_change;
  // A write committing the enable also covers an edge seen just before it
  assign sref_en = ctrl_q[fifo_align_pkg::BIT_SYSREF_EN]
                   | (ctrl_wr & wr_data_q[fifo_align_pkg::BIT_SYSREF_EN]);
  assign sref_misaligned = sysref_edge && (phase_q != fifo_align_pkg::PHASE_ZERO);
  assign sref_realign    = sysref_edge && sref_en;
  assign stb_change      = stb_done && (lhold_q != phase_q);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_q <= fifo_align_pkg::PHASE_ZERO;
    end else if (sref_realign) begin
      phase_q <= fifo_align_pkg::PHASE_ONE;
    end else if (stb_change) begin
      phase_q <= lhold_q + fifo_align_pkg::PHASE_ONE;
    end else begin
      phase_q <= phase_q + fifo_align_pkg::PHASE_ONE;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      synced_q <= 1'b0;
    end else if (!datapath_enable) begin
      synced_q <= 1'b0;
    end else if (sref_realign) begin
      synced_q <= 1'b1;
    end
  end

  // Sticky alarms; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      alarm_o <= '0;
    end else begin
      alarm_o.realigned <= (alarm_o.realigned & ~alarm_clear_i.realigned)
                           | stb_change
                           | (sref_realign & sref_misaligned);
      alarm_o.misalign  <= (alarm_o.misalign & ~alarm_clear_i.misalign)
                           | sref_misaligned;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fifo_phase_o <= fifo_align_pkg::PHASE_ZERO;
    end else begin
      fifo_phase_o <= phase_q;
    end
  end

  // ----------------------------------------
  // Latency measure and release timing
  // ----------------------------------------
  logic [4:0] lat_cnt_q, trim;
  logic       measuring_q, rel_pend_q;

  assign trim = (lane_mode_i == fifo_align_pkg::LANE_MODE_ZERO)
                ? fifo_align_pkg::LAT_TRIM_MODE0 : fifo_align_pkg::LAT_TRIM_OTHER;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lat_cnt_q   <= 5'h00;
      measuring_q <= 1'b0;
      latency_q   <= 5'h00;
    end else if (sysref_edge) begin
      lat_cnt_q   <= 5'h00;
      measuring_q <= 1'b1;
    end else if (measuring_q) begin
      if (sample_avail_i) begin
        measuring_q <= 1'b0;
        latency_q   <= (lat_cnt_q > trim) ? lat_cnt_q - trim : 5'h00;
      end else if (lat_cnt_q != fifo_align_pkg::LAT_MAX) begin
        lat_cnt_q <= lat_cnt_q + 5'h01;
      end
    end
  end

  logic [4:0] rel_cnt_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rel_cnt_q       <= 5'h00;
      rel_pend_q      <= 1'b0;
      release_start_o <= 1'b0;
    end else begin
      release_start_o <= 1'b0;
      if (sysref_edge) begin
        rel_cnt_q  <= 5'h00;
        rel_pend_q <= 1'b1;
      end else if (rel_pend_q) begin
        if (rel_cnt_q == fifo_release_delay_i) begin
          rel_pend_q      <= 1'b0;
          release_start_o <= 1'b1;
        end else begin
          rel_cnt_q <= rel_cnt_q + 5'h01;
        end
      end
    end
  end
endmodule : sample_fifo_alignment_control
`default_nettype wire

// ===== common/fifo_align_pkg.sv
// Constants and types for the sample FIFO alignment control block
package fifo_align_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [14:0] ADDR_LATENCY_RB3 = 15'h0213;
  localparam logic [14:0] ADDR_ALIGN_CTRL  = 15'h0220;
  localparam logic [7:0]  ALIGN_CTRL_RESET = 8'h00;
  localparam int          BIT_SYSREF_EN    = 0;
  localparam int          BIT_STROBE_REQ   = 1;
  // ----------------------------------------
  // Serial port frame: R/W bit, 15-bit address, 8-bit data
  // ----------------------------------------
  localparam int          SPI_FRAME_BITS   = 24;
  localparam int          SPI_ADDR_BITS    = 16;
  localparam logic [4:0]  SPI_CNT_ADDR     = 5'h10;
  localparam logic [4:0]  SPI_CNT_LAST     = 5'h17;
  // ----------------------------------------
  // Alignment and latency
  // ----------------------------------------
  localparam int          PHASE_W          = 3;
  localparam logic [2:0]  PHASE_ZERO       = 3'h0;
  localparam logic [2:0]  PHASE_ONE        = 3'h1;
  localparam logic [4:0]  LAT_TRIM_MODE0   = 5'h03;
  localparam logic [4:0]  LAT_TRIM_OTHER   = 5'h01;
  localparam logic [4:0]  LAT_MAX          = 5'h1F;
  localparam logic [1:0]  LANE_MODE_ZERO   = 2'h0;

  typedef enum logic [1:0] {
    SPI_IDLE  = 2'b01,
    SPI_SHIFT = 2'b10
  } spi_state_t;

  typedef enum logic [2:0] {
    STB_IDLE = 3'b001,
    STB_WAIT = 3'b010,
    STB_DONE = 3'b100
  } strobe_state_t;

  typedef struct packed {
    logic realigned;
    logic misalign;
  } alarm_t;
endpackage : fifo_align_pkg

// ===== tb/fifo_align_asserts.sv
// Checker for the sample FIFO alignment control block
`timescale 1ns/10ps
`default_nettype none
module fifo_align_asserts (
  input wire logic                   clk_i,
  input wire logic                   reset_i,
  input wire logic                   spi_cs_n_i,
  input wire logic                   sysref_i,
  input wire logic                   datapath_enable_i,
  input wire fifo_align_pkg::alarm_t alarm_clear_i,
  input wire fifo_align_pkg::alarm_t alarm_o,
  input wire logic [2:0]             fifo_phase_o,
  input wire logic                   release_start_o
);
  logic [5:0] sr_age_q;
  logic [5:0] ev_age_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Cycles since the last SYSREF rise, and since any realign cause
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) sr_age_q <= 6'h00;
    else if ($rose(sysref_i)) sr_age_q <= 6'h00;
    else if (sr_age_q != 6'h3F) sr_age_q <= sr_age_q + 6'h01;
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) ev_age_q <= 6'h00;
    else if ($rose(sysref_i) || !spi_cs_n_i || !datapath_enable_i) ev_age_q <= 6'h00;
    else if (ev_age_q != 6'h3F) ev_age_q <= ev_age_q + 6'h01;
  end
  chk_reset_clear: assert property ($fell(reset_i) |-> alarm_o == 2'h0 && !release_start_o)
    else $error("alarm or release set after reset");
  chk_realign_sticky: assert property (alarm_o.realigned && !alarm_clear_i.realigned |=> alarm_o.realigned)
    else $error("realigned alarm lost");
  chk_misalign_sticky: assert property (alarm_o.misalign && !alarm_clear_i.misalign |=> alarm_o.misalign)
    else $error("misalign alarm lost");
  chk_misalign_cause: assert property ($rose(alarm_o.misalign) |-> sr_age_q <= 6'h08)
    else $error("misalign alarm without SYSREF");
  chk_quiet_phase: assert property (ev_age_q > 6'h18 |-> fifo_phase_o == $past(fifo_phase_o) + 3'h1)
    else $error("phase moved without a request");
  chk_quiet_alarm: assert property (ev_age_q > 6'h18 |-> !$rose(alarm_o.realigned))
    else $error("realign without a request");
  chk_release_pulse: assert property (release_start_o |=> !release_start_o)
    else $error("release pulse too long");
  chk_release_cause: assert property (release_start_o |-> sr_age_q >= 6'h02 && sr_age_q <= 6'h28)
    else $error("release not tied to SYSREF");
  chk_realign_jump: assert property ($rose(alarm_o.realigned) |=> fifo_phase_o != $past(fifo_phase_o) + 3'h1)
    else $error("realigned alarm without a phase change");
  cov_release: cover property (release_start_o);
  cov_realign: cover property ($rose(alarm_o.realigned));
  cov_misalign: cover property ($rose(alarm_o.misalign));
endmodule : fifo_align_asserts
bind sample_fifo_alignment_control fifo_align_asserts u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .spi_cs_n_i(spi_cs_n_i), .sysref_i(sysref_i),
  .datapath_enable_i(datapath_enable_i), .alarm_clear_i(alarm_clear_i),
  .alarm_o(alarm_o), .fifo_phase_o(fifo_phase_o), .release_start_o(release_start_o)
);
`default_nettype wire

// ===== tb/lane_source_model.sv
// Lane-side source model: free-running lane clock and bank strobes
`timescale 1ns/10ps
`default_nettype none
module lane_source_model (
  input  wire logic send0_i,
  input  wire logic send2_i,
  output logic      lane_clk_o,
  output logic      strobe_bank0_o,
  output logic      strobe_bank2_o
);
  initial begin
    lane_clk_o = 1'b0;
    strobe_bank0_o = 1'b0;
    strobe_bank2_o = 1'b0;
    #3.7;
    forever begin
      #6 lane_clk_o = ~lane_clk_o;
      if (lane_clk_o) begin
        strobe_bank0_o <= send0_i;
        strobe_bank2_o <= send2_i;
      end
    end
  end
endmodule : lane_source_model
`default_nettype wire

// ===== tb/sample_fifo_alignment_control_tb.sv
// Testbench for the sample FIFO alignment control block
`timescale 1ns/10ps
`default_nettype none
module sample_fifo_alignment_control_tb;
  logic                   clk_i, reset_i, lane_clk, sclk, cs_n, sdi, sdo, sysref;
  logic                   stb0, stb2, send0, send2, bank0, datapath_enable, avail, rel, sdo_oe;
  logic [1:0]             mode;
  logic [4:0]             dly;
  logic [2:0]             phase;
  logic [7:0]             res_v, rd;
  fifo_align_pkg::alarm_t clr, alarm;
  logic [7:0]             exp_q[$];
  logic [2:0]             ph_q[$];
  event                   res_ev, alm_ev;
  int                     n_fail, checked, cyc, ref_t, t, n, lat;

  sample_fifo_alignment_control u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .lane_clk_i(lane_clk), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
    .sysref_i(sysref), .strobe_bank0_i(stb0), .strobe_bank2_i(stb2),
    .bank0_active_i(bank0), .datapath_enable_i(datapath_enable), .lane_mode_i(mode),
    .fifo_release_delay_i(dly), .sample_avail_i(avail), .alarm_clear_i(clr),
    .alarm_o(alarm), .fifo_phase_o(phase), .release_start_o(rel)
  );
  lane_source_model u_lane (.send0_i(send0), .send2_i(send2), .lane_clk_o(lane_clk),
    .strobe_bank0_o(stb0), .strobe_bank2_o(stb2));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // One full frame; read data is taken on the rising serial clock of each of the 8 data bits
  task automatic spi(input logic [23:0] f);
    cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi = f[i];
      sclk = 1'b0;
      repeat (4) @(negedge clk_i);
      sclk = 1'b1;
      if (i < 8) begin
        rd[i] = sdo;
        cmp({7'h00, sdo_oe}, {7'h00, f[23]});
      end
      repeat (4) @(negedge clk_i);
    end
    sclk = 1'b0;
    repeat (4) @(negedge clk_i);
    cs_n = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask : spi
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    spi({1'b0, a, d});
  endtask : wr
  task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    spi({1'b1, a, 8'h00});
    res_v = rd;
    -> res_ev;
  endtask : rd_chk
  task automatic snap(input logic [1:0] e);
    repeat (16) @(negedge clk_i);
    exp_q.push_back({6'h00, e});
    -> alm_ev;
  endtask : snap
  task automatic clr_alm();
    clr = 2'h3;
    @(negedge clk_i);
    clr = 2'h0;
  endtask : clr_alm
  // SYSREF pulse at cycle at; phase at release follows the last alignment
  task automatic sr(input int at, input bit align);
    while (cyc < at) @(negedge clk_i);
    if (align) ref_t = at;
    ph_q.push_back(3'(at - ref_t + dly + 1));
    sysref = 1'b1;
    repeat (3) @(negedge clk_i);
    sysref = 1'b0;
  endtask : sr
  task automatic print_verdict();
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  always @(res_ev) cmp(res_v, exp_q.pop_front());
  always @(alm_ev) cmp({6'h00, alarm}, exp_q.pop_front());
  always @(negedge clk_i) begin
    if (rel === 1'b1 && ph_q.size() > 0) cmp({5'h00, phase}, {5'h00, ph_q.pop_front()});
  end

  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end

  initial begin
    {reset_i, cs_n, datapath_enable, bank0} = 4'hF;
    {sclk, sdi, sysref, send0, send2, avail} = 6'h00;
    mode = 2'h0;
    clr = 2'h0;
    void'($urandom(32'hDE14));
    dly = 5'($urandom_range(15, 0));
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rd_chk(15'h0213, 8'h00);
    rd_chk(15'h0220, 8'h00);
    wr(15'h0100, 8'hFF);
    rd_chk(15'h0100, 8'h00);
    wr(15'h0220, 8'hFD);
    rd_chk(15'h0220, 8'hFD);
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      n = $urandom_range(7, 0);
      sr(cyc + 2, 1'b1);
      for (int k = 0; k < 60 && rel !== 1'b1; k++) @(negedge clk_i);
      repeat (n) @(negedge clk_i);
      avail = 1'b1;
      lat = dly + 1 + n - ((m == 0) ? 3 : 1);
      rd_chk(15'h0213, (lat < 0) ? 8'h00 : 8'(lat));
      avail = 1'b0;
    end
    clr_alm();
    t = ref_t + 8 * ((cyc - ref_t) / 8 + 3);
    sr(t, 1'b1);
    snap(2'h0);
    sr(t + 67, 1'b1);
    snap(2'h3);
    clr_alm();
    wr(15'h0220, 8'h00);
    sr(ref_t + 325, 1'b0);
    snap(2'h1);
    clr_alm();
    wr(15'h0220, 8'h02);
    sr(ref_t + 8 * ((cyc - ref_t) / 8 + 2), 1'b0);
    snap(2'h0);
    datapath_enable = 1'b0;
    repeat (8) @(negedge clk_i);
    datapath_enable = 1'b1;
    wr(15'h0220, 8'h00);
    bank0 = 1'b0;
    send2 = 1'b1;
    repeat (2) @(negedge clk_i);
    send2 = 1'b0;
    wr(15'h0220, 8'h02);
    rd_chk(15'h0220, 8'h02);
    repeat (20) @(negedge clk_i);
    print_verdict();
  end
endmodule : sample_fifo_alignment_control_tb
`default_nettype wire
